// file: rtl/tlcr_pkg.sv
// Shared constants and types for the tape line character receiver
package tlcr_pkg;
  localparam int TLCR_CLK_PERIOD_NS = 50;
  localparam int TLCR_BIT_TIME_NS = 952000;
  localparam int TLCR_BIT_CYC = TLCR_BIT_TIME_NS / TLCR_CLK_PERIOD_NS;
  localparam int TLCR_DATA_BITS = 8;
  localparam int TLCR_CNT_W = 16;
  localparam int TLCR_SYNC_W = 6;
  // Register byte offsets
  localparam logic [7:0] TLCR_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TLCR_ADDR_STAT = 8'h04;
  localparam logic [7:0] TLCR_ADDR_DATA = 8'h08;
  localparam logic [31:0] TLCR_CTRL_RST = 32'h0000_0000;
  // Control register fields
  localparam int TLCR_CTL_UNATT = 0;
  localparam int TLCR_CTL_RC_REQ = 1;
  localparam int TLCR_CTL_RATE_EXT = 2;
  localparam int TLCR_CTL_SA_TOGGLE = 3;
  // Status register fields
  localparam int TLCR_ST_RING = 0;
  localparam int TLCR_ST_DSR = 1;
  localparam int TLCR_ST_CD = 2;
  localparam int TLCR_ST_SSTOP = 3;
  localparam int TLCR_ST_SA = 4;
  localparam int TLCR_ST_BUSY = 5;
  localparam int TLCR_ST_DTR = 6;
  localparam int TLCR_ST_SRC = 7;
  // Synchroniser lane positions
  localparam int TLCR_IN_RING = 0;
  localparam int TLCR_IN_DSR = 1;
  localparam int TLCR_IN_CD = 2;
  localparam int TLCR_IN_RXD = 3;
  localparam int TLCR_IN_LT = 4;
  localparam int TLCR_IN_ALARM = 5;
  localparam logic [1:0] TLCR_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TLCR_HTRANS_SEQ = 2'h3;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT, RX_SAMPLE} tlcr_rx_e;
endpackage

// file: rtl/tlcr_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tlcr_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] agree;
  logic [W-1:0] nxt_out;

  assign agree = ~(s2_ff ^ s3_ff);
  assign nxt_out = (agree & s3_ff) | (~agree & out_ff);
  assign dout = out_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      out_ff <= INIT;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end
endmodule
`default_nettype wire

// file: rtl/tlcr_top.sv
// Line front end: modem handshake, reverse channel and start-stop character receiver
//
// Summary of operation
// - Terminal-ready stays on except while ringing or while held off after a ring
// - Ring drops terminal-ready; held off if blocked
// - Set-ready starts motors, lamp, enables carrier detect
// - Carrier removes blind, clears stopped, enables punch
// - Bit time is 0.952 ms oscillator period
// - Idle on mark; start bit begins assembly
// - Each bit clock shifts one received bit
// - Sample pulse exactly one bit time wide
// - Eight data levels stable during sample pulse
// - Mark drives level high, space low
// - After sample, wait for next start bit
// - Request bit asks reverse channel on/off
// - Request ANDed with all reverse-channel blinds
// - Stop/alarm forces reverse channel off
// - Modem levels mapped: mark one, asserted high
// - Rate select: internal clock only supported
// - Carrier drop lights sender-stopped indication
// - Return to reset pulses error-correction clear
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tlcr_top import tlcr_pkg::*; #(
  parameter int BIT_CYC = TLCR_BIT_CYC,
  parameter int DATA_BITS = TLCR_DATA_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ring_ind,
  input wire logic set_ready,
  input wire logic carrier_det,
  input wire logic rx_data,
  input wire logic low_tape,
  input wire logic ec_alarm,
  output logic term_ready,
  output logic send_rev_chan,
  output logic motor_start,
  output logic verifier_lamp,
  output logic punch_inhibit,
  output logic sender_stopped,
  output logic stop_alarm,
  output logic ec_reset,
  output logic char_sample,
  output logic [DATA_BITS-1:0] data_level
);
  localparam logic [TLCR_CNT_W-1:0] BIT_LD = TLCR_CNT_W'(BIT_CYC - 1);
  localparam logic [TLCR_CNT_W-1:0] HALF_LD = TLCR_CNT_W'(BIT_CYC / 2 - 1);
  localparam logic [3:0] LAST_BIT = 4'(DATA_BITS - 1);

  // Synchronised modem and station inputs
  logic [TLCR_SYNC_W-1:0] pins_raw;
  logic [TLCR_SYNC_W-1:0] pins_s;
  logic ring_s;
  logic dsr_s;
  logic cd_s;
  logic rxd_s;
  logic lt_s;
  logic alarm_s;

  // Inputs arrive already translated: asserted control high, mark high
  assign pins_raw = {ec_alarm, low_tape, rx_data, carrier_det, set_ready, ring_ind};
  tlcr_sync3 #(.W(TLCR_SYNC_W), .INIT(TLCR_SYNC_W'(1) << TLCR_IN_RXD)) u_sync (
    .clk(clk),
    .rst(rst),
    .din(pins_raw),
    .dout(pins_s)
  );
  assign ring_s = pins_s[TLCR_IN_RING];
  assign dsr_s = pins_s[TLCR_IN_DSR];
  assign cd_s = pins_s[TLCR_IN_CD];
  assign rxd_s = pins_s[TLCR_IN_RXD];
  assign lt_s = pins_s[TLCR_IN_LT];
  assign alarm_s = pins_s[TLCR_IN_ALARM];

  // Bus slave state
  logic wr_ph_ff;
  logic [7:0] wadr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic [31:0] ctrl_ff;
  logic acc;
  logic wr_ctrl;
  logic sa_toggle;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  // Station control state
  logic ring_hold_ff;
  logic term_ready_ff;
  logic send_rc_ff;
  logic motor_ff;
  logic punch_inh_ff;
  logic sstop_ff;
  logic cd_prev_ff;
  logic sa_ff;
  logic ec_reset_ff;
  logic cd_eff;
  logic dtr_block;
  logic rc_blind;
  logic rx_en;
  logic nxt_sa;
  logic nxt_ring_hold;
  logic nxt_send_rc;
  logic nxt_sstop;

  // Receiver state
  tlcr_rx_e rx_st_ff;
  tlcr_rx_e nxt_rx_st;
  logic [TLCR_CNT_W-1:0] cnt_ff;
  logic [TLCR_CNT_W-1:0] nxt_cnt;
  logic [3:0] idx_ff;
  logic [3:0] nxt_idx;
  logic [DATA_BITS-1:0] shift_ff;
  logic [DATA_BITS-1:0] nxt_shift;
  logic [DATA_BITS-1:0] level_ff;
  logic [DATA_BITS-1:0] nxt_level;
  logic samp_ff;
  logic nxt_samp;
  logic cnt_zero;

  assign acc = hsel && hready && (htrans == TLCR_HTRANS_NONSEQ || htrans == TLCR_HTRANS_SEQ);
  assign wr_ctrl = wr_ph_ff && wadr_ff == TLCR_ADDR_CTRL;
  assign sa_toggle = wr_ctrl && hwdata[TLCR_CTL_SA_TOGGLE];
  assign stat_word = {24'h00_0000, send_rc_ff, term_ready_ff, rx_st_ff != RX_IDLE, sa_ff,
                      sstop_ff, cd_eff, dsr_s, ring_s};
  assign rd_word = (haddr[7:0] == TLCR_ADDR_CTRL) ? ctrl_ff :
                   (haddr[7:0] == TLCR_ADDR_STAT) ? stat_word :
                   (haddr[7:0] == TLCR_ADDR_DATA) ? 32'(level_ff) : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ph_ff <= 1'b0;
      wadr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b0;
      ctrl_ff <= TLCR_CTRL_RST;
    end else begin
      wr_ph_ff <= acc && hwrite;
      wadr_ff <= haddr[7:0];
      hrdata_ff <= (acc && !hwrite) ? rd_word : 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      if (wr_ctrl) begin
        // The toggle bit is a strobe and never stored
        ctrl_ff <= hwdata & ~(32'h0000_0001 << TLCR_CTL_SA_TOGGLE);
      end
    end
  end

  // Carrier is only seen while set-ready is on
  assign cd_eff = cd_s && dsr_s;
  assign dtr_block = !ctrl_ff[TLCR_CTL_UNATT] && (lt_s || alarm_s);
  assign nxt_ring_hold = ring_s || (ring_hold_ff && dtr_block);
  assign rc_blind = !cd_eff;
  // Request gated with every blind; stop/alarm always wins
  assign nxt_send_rc = ctrl_ff[TLCR_CTL_RC_REQ] && !rc_blind && !sa_ff;
  // An alarm sets stop even in the cycle software toggles it
  assign nxt_sa = alarm_s || (sa_ff ^ sa_toggle);
  assign nxt_sstop = (cd_prev_ff && !cd_eff) || (sstop_ff && !(cd_eff && !cd_prev_ff));
  // External rate clock is not offered; receiver runs only on the internal oscillator
  assign rx_en = !ctrl_ff[TLCR_CTL_RATE_EXT];

  always_ff @(posedge clk) begin
    if (rst) begin
      ring_hold_ff <= 1'b0;
      term_ready_ff <= 1'b0;
      send_rc_ff <= 1'b0;
      motor_ff <= 1'b0;
      punch_inh_ff <= 1'b1;
      sstop_ff <= 1'b0;
      cd_prev_ff <= 1'b0;
      sa_ff <= 1'b0;
      ec_reset_ff <= 1'b0;
    end else begin
      ring_hold_ff <= nxt_ring_hold;
      term_ready_ff <= !nxt_ring_hold;
      send_rc_ff <= nxt_send_rc;
      motor_ff <= dsr_s;
      punch_inh_ff <= !cd_eff;
      sstop_ff <= nxt_sstop;
      cd_prev_ff <= cd_eff;
      sa_ff <= nxt_sa;
      ec_reset_ff <= sa_ff && !nxt_sa;
    end
  end

  // Character receiver
  assign cnt_zero = cnt_ff == '0;

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_cnt = cnt_ff - TLCR_CNT_W'(1);
    nxt_idx = idx_ff;
    nxt_shift = shift_ff;
    nxt_level = level_ff;
    nxt_samp = samp_ff;
    unique case (rx_st_ff)
      RX_IDLE: begin
        nxt_cnt = HALF_LD;
        if (rx_en && !rxd_s) begin
          nxt_rx_st = RX_START;
        end
      end
      RX_START: begin
        if (cnt_zero) begin
          // Recheck start bit mid-bit to reject glitches
          nxt_rx_st = rxd_s ? RX_IDLE : RX_SHIFT;
          nxt_cnt = BIT_LD;
          nxt_idx = 4'h0;
        end
      end
      RX_SHIFT: begin
        if (cnt_zero) begin
          nxt_shift = {rxd_s, shift_ff[DATA_BITS-1:1]};
          nxt_idx = idx_ff + 4'h1;
          nxt_cnt = BIT_LD;
          if (idx_ff == LAST_BIT) begin
            nxt_rx_st = RX_SAMPLE;
            nxt_level = {rxd_s, shift_ff[DATA_BITS-1:1]};
            nxt_samp = 1'b1;
          end
        end
      end
      RX_SAMPLE: begin
        if (cnt_zero) begin
          nxt_rx_st = RX_IDLE;
          nxt_samp = 1'b0;
          nxt_cnt = HALF_LD;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st_ff <= RX_IDLE;
      cnt_ff <= '0;
      idx_ff <= 4'h0;
      shift_ff <= '0;
      level_ff <= '0;
      samp_ff <= 1'b0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      shift_ff <= nxt_shift;
      level_ff <= nxt_level;
      samp_ff <= nxt_samp;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign term_ready = term_ready_ff;
  assign send_rev_chan = send_rc_ff;
  assign motor_start = motor_ff;
  assign verifier_lamp = motor_ff;
  assign punch_inhibit = punch_inh_ff;
  assign sender_stopped = sstop_ff;
  assign stop_alarm = sa_ff;
  assign ec_reset = ec_reset_ff;
  assign char_sample = samp_ff;
  assign data_level = level_ff;

  // Checks
  int samp_len;
  always_ff @(posedge clk) begin
    if (rst || !samp_ff) begin
      samp_len <= 0;
    end else begin
      samp_len <= samp_len + 1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_one_pulse;
    ec_reset_ff ##1 !ec_reset_ff;
  endsequence
  sequence seq_carrier_up;
    !cd_eff ##1 cd_eff;
  endsequence

  chk_dtr_ring_off: assert property (ring_s |=> !term_ready_ff)
    else $error("terminal ready on during ring");
  chk_dtr_idle_on: assert property (!ring_s && !ring_hold_ff |=> term_ready_ff)
    else $error("terminal ready off outside ring");
  chk_motor_on_dsr: assert property (dsr_s |=> motor_start && verifier_lamp)
    else $error("motors not started on set ready");
  chk_carrier_up: assert property (seq_carrier_up |=> !punch_inhibit_w() && !sstop_ff)
    else $error("carrier up did not enable punch");
  chk_stop_lamp: assert property ($fell(cd_eff) |=> sstop_ff)
    else $error("sender stopped not lit on carrier loss");
  chk_rc_stop_off: assert property (sa_ff |=> !send_rc_ff)
    else $error("reverse channel on in stop state");
  chk_rc_gate_and: assert property (send_rc_ff |-> $past(ctrl_ff[TLCR_CTL_RC_REQ] && cd_eff))
    else $error("reverse channel on without request and carrier");
  chk_sample_width: assert property ($fell(samp_ff) |-> samp_len == BIT_CYC)
    else $error("sample pulse not one bit time");
  chk_data_stable: assert property (samp_ff && $past(samp_ff) |-> $stable(level_ff))
    else $error("data levels changed during sample");
  chk_idle_on_mark: assert property (rx_st_ff == RX_IDLE && rxd_s |=> rx_st_ff == RX_IDLE)
    else $error("receiver left idle on mark");
  chk_ecr_pulse: assert property ($fell(sa_ff) |-> seq_one_pulse)
    else $error("no single reset pulse on stop release");

  function automatic logic punch_inhibit_w();
    return punch_inh_ff;
  endfunction
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking testbench for the tape line character receiver
`timescale 1ns/1ps
`default_nettype none
module testbench import tlcr_pkg::*;;
  localparam int BIT = 16;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, low_tape, ec_alarm;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic ring_ind, set_ready, carrier_det, rx_data, term_ready, send_rev_chan;
  logic motor_start, verifier_lamp, punch_inhibit, sender_stopped, stop_alarm, ec_reset, char_sample;
  logic [7:0] data_level, last;
  int num_errors = 0, samples_checked = 0, seed = 81949, n_samp = 0, n_ecr = 0, k;
  tlcr_top #(.BIT_CYC(BIT)) dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ring_ind(ring_ind), .set_ready(set_ready),
    .carrier_det(carrier_det), .rx_data(rx_data), .low_tape(low_tape), .ec_alarm(ec_alarm),
    .term_ready(term_ready), .send_rev_chan(send_rev_chan), .motor_start(motor_start),
    .verifier_lamp(verifier_lamp), .punch_inhibit(punch_inhibit), .sender_stopped(sender_stopped),
    .stop_alarm(stop_alarm), .ec_reset(ec_reset), .char_sample(char_sample), .data_level(data_level));
  tlcr_modem #(.BIT_CYC(BIT)) mdm (.clk(clk), .ring_ind(ring_ind), .set_ready(set_ready),
    .carrier_det(carrier_det), .rx_data(rx_data));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge char_sample) n_samp++;
  always @(posedge ec_reset) n_ecr++;
  task automatic stop_test();
    $display("Checked %0d samples, %0d errors", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single AHB transfer; read data is taken at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    hsize <= 3'h2;
    htrans <= TLCR_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? wd : $random(seed);
    // Select and size are don't-care while the bus idles
    hsel <= 1'($random(seed));
    hsize <= 3'($random(seed));
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask
  // Status word expected from the modem and station levels
  function automatic logic [31:0] stat_exp(input logic dsr, input logic cd, input logic trdy, input logic src);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[TLCR_ST_DSR] = dsr;
    s[TLCR_ST_CD] = cd;
    s[TLCR_ST_DTR] = trdy;
    s[TLCR_ST_SRC] = src;
    return s;
  endfunction
  task automatic rx_char(input logic [7:0] c);
    int w;
    int t;
    w = 0;
    t = 0;
    fork
      mdm.send_char(c);
      begin
        while (char_sample !== 1'b1 && t < 12 * BIT) begin
          cyc(1);
          t++;
        end
        chk("data_level", {24'h0, c}, data_level);
        while (char_sample === 1'b1 && w < 2 * BIT) begin
          if (data_level !== c) t = -1;
          cyc(1);
          w++;
        end
      end
    join
    chk("sample width", BIT, w);
    chk("level stable", 1, t >= 0);
    last = c;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    {htrans, haddr, hwrite, hwdata, low_tape, ec_alarm} = '0;
    {rst, hsel} = 2'h3;
    hsize = 3'h2;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk("punch_inhibit reset", 1, punch_inhibit);
    chk("sample reset", 0, char_sample);
    chk("hreadyout after reset", 1, hreadyout);
    cyc(3);
    chk("term_ready idle", 1, term_ready);
    bus(0, TLCR_ADDR_CTRL, 0);
    chk("ctrl reset", TLCR_CTRL_RST, rd);
    bus(0, 8'h10, 0);
    chk("unmapped read", 0, rd);
    $display("Test reset and bus done");
    fork
      mdm.ring(20);
      begin
        cyc(8);
        chk("term_ready ringing", 0, term_ready);
      end
    join
    cyc(8);
    chk("term_ready after ring", 1, term_ready);
    low_tape <= 1'b1;
    cyc(8);
    mdm.ring(20);
    cyc(10);
    chk("term_ready blocked", 0, term_ready);
    bus(1, TLCR_ADDR_CTRL, 32'h1);
    cyc(8);
    chk("term_ready unattended", 1, term_ready);
    low_tape <= 1'b0;
    $display("Test ring done");
    mdm.carrier(1'b1);
    cyc(10);
    chk("punch_inhibit no set_ready", 1, punch_inhibit);
    mdm.data_mode(1'b1);
    cyc(8);
    chk("motor_start", 1, motor_start);
    chk("verifier_lamp", 1, verifier_lamp);
    chk("punch_inhibit", 0, punch_inhibit);
    chk("sender_stopped", 0, sender_stopped);
    bus(1, TLCR_ADDR_CTRL, 32'h3);
    cyc(8);
    chk("send_rev_chan on", 1, send_rev_chan);
    bus(0, TLCR_ADDR_STAT, 0);
    chk("status", stat_exp(1'b1, 1'b1, 1'b1, 1'b1), rd);
    chk("hresp", 0, hresp);
    bus(1, TLCR_ADDR_CTRL, 32'h1);
    cyc(8);
    chk("send_rev_chan off", 0, send_rev_chan);
    bus(1, TLCR_ADDR_CTRL, 32'h3);
    mdm.carrier(1'b0);
    cyc(10);
    chk("sender_stopped drop", 1, sender_stopped);
    chk("send_rev_chan blind", 0, send_rev_chan);
    mdm.carrier(1'b1);
    cyc(10);
    chk("send_rev_chan restored", 1, send_rev_chan);
    bus(1, TLCR_ADDR_CTRL, 32'hB);
    cyc(8);
    chk("send_rev_chan stopped", 0, send_rev_chan);
    bus(1, TLCR_ADDR_CTRL, 32'hB);
    cyc(4);
    chk("stop_alarm cleared", 0, stop_alarm);
    chk("ec_reset count", 1, n_ecr);
    ec_alarm <= 1'b1;
    cyc(8);
    chk("alarm stop", 1, stop_alarm);
    chk("alarm rev chan", 0, send_rev_chan);
    ec_alarm <= 1'b0;
    cyc(8);
    bus(1, TLCR_ADDR_CTRL, 32'hB);
    cyc(8);
    chk("ec_reset after alarm", 2, n_ecr);
    chk("rev chan resumed", 1, send_rev_chan);
    $display("Test handshake done");
    bus(1, TLCR_ADDR_CTRL, 32'h7);
    k = n_samp;
    mdm.send_char(8'h5A);
    cyc(BIT);
    chk("rate ext ignored", k, n_samp);
    bus(1, TLCR_ADDR_CTRL, 32'h3);
    k = n_samp;
    mdm.space(3);
    cyc(3 * BIT);
    chk("glitch ignored", k, n_samp);
    rx_char(8'h00);
    rx_char(8'hFF);
    rx_char(8'hA5);
    for (int i = 0; i < 6; i++) rx_char(8'($random(seed)));
    bus(0, TLCR_ADDR_DATA, 0);
    chk("data register", {24'h0, last}, rd);
    $display("Test receive done");
    k = n_samp;
    fork
      mdm.send_char(8'hFF);
      begin
        cyc(3 * BIT);
        rst <= 1'b1;
        cyc(2);
        chk("hreadyout in reset", 0, hreadyout);
        rst <= 1'b0;
        cyc(1);
        chk("hreadyout after mid reset", 1, hreadyout);
        chk("sample mid reset", 0, char_sample);
        chk("level mid reset", 0, data_level);
      end
    join
    chk("no char after reset", k, n_samp);
    bus(0, TLCR_ADDR_STAT, 0);
    chk("status after reset", stat_exp(1'b1, 1'b1, 1'b1, 1'b0), rd);
    rx_char(8'($random(seed)));
    k = n_samp;
    cyc(4 * BIT);
    chk("idle on mark", k, n_samp);
    $display("Test mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire

// file: verification/tlcr_modem.sv
// Behavioural data set model driving the modem leads of the receiver
`timescale 1ns/1ps
`default_nettype none
module tlcr_modem #(
  parameter int BIT_CYC = 16,
  parameter int DSR_DLY = 20
) (
  input wire logic clk,
  output logic ring_ind,
  output logic set_ready,
  output logic carrier_det,
  output logic rx_data
);
  initial begin
    {ring_ind, set_ready, carrier_det} = 3'h0;
    rx_data = 1'b1;
  end
  task automatic ring(input int n);
    ring_ind <= 1'b1;
    repeat (n) @(posedge clk);
    ring_ind <= 1'b0;
  endtask
  // Set-ready follows entry to data mode after a fixed delay
  task automatic data_mode(input logic on);
    if (on) repeat (DSR_DLY) @(posedge clk);
    set_ready <= on;
  endtask
  task automatic carrier(input logic on);
    carrier_det <= on;
  endtask
  // Short space that is gone before mid start bit
  task automatic space(input int n);
    rx_data <= 1'b0;
    repeat (n) @(posedge clk);
    rx_data <= 1'b1;
  endtask
  // Start, eight data bits first bit first, two stop bits; mark is 1
  task automatic send_char(input logic [7:0] c);
    logic [10:0] f;
    f = {2'h3, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_data <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire
